// ===== rwp_consts.svh
`ifndef RWP_CONSTS_SVH
`define RWP_CONSTS_SVH
`define RWP_OPT_RATIO_LSB 0
`define RWP_OPT_ASSIGN_BIT 3
`define RWP_OPT_EDGE_BIT 4
`define RWP_OPT_SOURCE_BIT 5
`define RWP_OPT_RESET 8'hFF
`define RWP_COUNT_RESET 8'h00
`define RWP_COUNT_MAX 8'hFF
`define RWP_CLK_HZ 200000000
`define RWP_GUARD_OSC_HZ 16000
`define RWP_GUARD_DIV (`RWP_CLK_HZ / `RWP_GUARD_OSC_HZ)
`endif

// ===== rwp_event_src.sv
`timescale 1ns/1ps
module rwp_event_src (
   // clock
   input wire logic clk,
   // control from bench
   input wire logic run,
   // pins toward the block
   output logic osc_in_pin,
   output logic counter_pin,
   // edge tallies
   output int n_rise,
   output int n_fall
);
   logic [2:0] phase;
   initial begin
      phase = 3'h0;
      counter_pin = 1'b0;
      n_rise = 0;
      n_fall = 0;
   end
   assign osc_in_pin = phase[1];
   // pin flips every 8 clk, osc every 2: stays under half the osc rate
   // stopping only after a fall leaves the pin low, so no half pulse escapes
   always @(posedge clk) begin
      phase <= phase + 3'h1;
      if (phase == 3'h7 && (run || counter_pin)) begin
         counter_pin <= ~counter_pin;
         if (counter_pin)
            n_fall <= n_fall + 1;
         else
            n_rise <= n_rise + 1;
      end
   end
endmodule

// ===== rwp_pkg.sv
package rwp_pkg;
   typedef logic [7:0] rwp_byte_t;
   typedef enum logic [2:0] {
      RWP_ST_RUN = 3'h1,
      RWP_ST_FIRE = 3'h2,
      RWP_ST_HOLD = 3'h4
   } rwp_guard_st_t;
endpackage

// ===== rwp_prescaler.sv
`timescale 1ns/1ps
`include "rwp_consts.svh"
module rwp_prescaler #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // shared prescaler link
   rwp_scale_if.scaler sif
);
   logic [WIDTH-1:0] count;
   logic [WIDTH:0] full_mask;
   logic [WIDTH-1:0] mask;
   logic [3:0] shift;
   logic wrap;

   // counter ratio 7 divides by 256, which needs eight count bits
   if (WIDTH < 8) begin : g_width_check
      $error("prescaler width must be at least 8");
   end

   // counter gets 2^(n+1), guard gets 2^n
   assign shift = sif.to_guard ? {1'b0, sif.ratio} : {1'b0, sif.ratio} + 4'h1;
   assign full_mask = ({{WIDTH{1'b0}}, 1'b1} << shift) - {{WIDTH{1'b0}}, 1'b1};
   assign mask = full_mask[WIDTH-1:0];
   assign wrap = (count & mask) == mask;
   assign sif.out_pulse = sif.tick && wrap && !sif.clear;

   // count has no software port at all
   always_ff @(posedge clk) begin
      if (!rst_b || sif.clear) begin
         count <= '0;
      end else if (sif.tick) begin
         count <= wrap ? '0 : count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   ratio_out_a: assert property (@(posedge clk) disable iff (!rst_b)
      sif.to_guard && sif.ratio == 3'h0 && sif.tick && !sif.clear |-> sif.out_pulse)
      else $error("guard ratio one lost");
   counter_even_a: assert property (@(posedge clk) disable iff (!rst_b)
      sif.out_pulse && !sif.to_guard |-> count[0])
      else $error("counter prescale odd");
endmodule

// ===== rwp_scale_if.sv
`timescale 1ns/1ps
interface rwp_scale_if;
   logic tick;
   logic clear;
   logic [2:0] ratio;
   logic to_guard;
   logic out_pulse;
   modport owner (output tick, output clear, output ratio, output to_guard, input out_pulse);
   modport scaler (input tick, input clear, input ratio, input to_guard, output out_pulse);
endinterface

// ===== rwp_timer.sv
`timescale 1ns/1ps
`include "rwp_consts.svh"
// How it works
// - eight-bit counter, instruction or pin clocked
// - option bit five picks the source
// - pin sampled each osc rising edge, slow source
// - option bit four picks falling edge
// - prescaled counter forms sixteen-bit chain
// - wrap sets rollover pending, interrupt if enabled
// - counter write clears assigned prescaler
// - test instruction blocks that cycle's increment
// - guard timer runs from own oscillator
// - fuse-enabled guard expiry resets device
// - option bit three assigns prescaler
// - three-bit field sets division ratio
// - prescaler count not software accessible
// - prescaler serves only one unit
// - option enable bit gates rollover interrupt
module rwp_timer #(
   parameter int GUARD_DIV = `RWP_GUARD_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // core timing and pins
   input wire logic instr_cycle,
   input wire logic osc_in_pin,
   input wire logic counter_pin,
   // option bits
   input wire logic [7:0] option_bits,
   input wire logic rollover_int_enable,
   input wire logic guard_enable_fuse,
   // software access
   input wire logic counter_write,
   input wire logic [7:0] counter_wdata,
   input wire logic counter_test,
   input wire logic guard_clear_instr,
   input wire logic pending_clear,
   // status
   output rwp_pkg::rwp_byte_t realtime_counter,
   output logic rollover_pending,
   output logic rollover_irq,
   output logic guard_reset
);
   rwp_scale_if sif ();
   rwp_pkg::rwp_guard_st_t guard_st;
   rwp_pkg::rwp_guard_st_t next_guard_st;
   logic osc_prev;
   logic pin_prev;
   logic osc_rise;
   logic pin_edge;
   logic src_tick;
   logic cnt_step;
   logic cnt_wrap;
   logic prescaler_assign;
   logic ext_source;
   logic falling_sel;
   logic [2:0] ratio;
   logic [31:0] osc_div;
   logic guard_osc_tick;
   logic guard_step;
   rwp_pkg::rwp_byte_t guard_count;
   logic guard_expire;

   // the divider compare needs at least two counts per guard tick
   if (GUARD_DIV < 2) begin : g_div_check
      $error("guard divider too small");
   end

   assign prescaler_assign = option_bits[`RWP_OPT_ASSIGN_BIT];
   assign ext_source = option_bits[`RWP_OPT_SOURCE_BIT];
   assign falling_sel = option_bits[`RWP_OPT_EDGE_BIT];
   assign ratio = option_bits[`RWP_OPT_RATIO_LSB +: 3];

   // pin is only looked at on osc rising edges; fast pins alias
   assign osc_rise = osc_in_pin && !osc_prev;
   assign pin_edge = falling_sel ? (pin_prev && !counter_pin)
      : (!pin_prev && counter_pin);
   assign src_tick = ext_source ? (osc_rise && pin_edge) : instr_cycle;

   // one prescaler, routed to exactly one consumer
   assign sif.to_guard = prescaler_assign;
   assign sif.ratio = ratio;
   assign sif.tick = prescaler_assign ? guard_osc_tick : src_tick;
   assign sif.clear = prescaler_assign ? guard_clear_instr : counter_write;

   rwp_prescaler #(.WIDTH(8)) u_scale (
      .clk(clk),
      .rst_b(rst_b),
      .sif(sif)
   );

   assign cnt_step = (prescaler_assign ? src_tick : sif.out_pulse) && !counter_test;
   assign cnt_wrap = cnt_step && !counter_write && realtime_counter == `RWP_COUNT_MAX;
   assign guard_step = prescaler_assign ? sif.out_pulse : guard_osc_tick;
   assign guard_expire = guard_step && !guard_clear_instr && guard_count == `RWP_COUNT_MAX;
   assign guard_osc_tick = osc_div == GUARD_DIV - 1;
   assign rollover_irq = rollover_pending && rollover_int_enable;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         osc_prev <= 1'b0;
         pin_prev <= 1'b0;
      end else if (osc_rise || !ext_source) begin
         osc_prev <= osc_in_pin;
         pin_prev <= counter_pin;
      end else begin
         osc_prev <= osc_in_pin;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         realtime_counter <= `RWP_COUNT_RESET;
      end else if (counter_write) begin
         realtime_counter <= counter_wdata;
      end else if (cnt_step) begin
         realtime_counter <= realtime_counter + 8'h01;
      end
   end

   // set wins over a same-cycle clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rollover_pending <= 1'b0;
      end else if (cnt_wrap) begin
         rollover_pending <= 1'b1;
      end else if (pending_clear) begin
         rollover_pending <= 1'b0;
      end
   end

   // free-running stand-in for the guard rc oscillator
   always_ff @(posedge clk) begin
      if (!rst_b || guard_osc_tick) begin
         osc_div <= 32'h0;
      end else begin
         osc_div <= osc_div + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || guard_clear_instr) begin
         guard_count <= `RWP_COUNT_RESET;
      end else if (guard_step) begin
         guard_count <= guard_count + 8'h01;
      end
   end

   always_comb begin
      next_guard_st = guard_st;
      case (guard_st)
         rwp_pkg::RWP_ST_RUN: begin
            if (guard_expire && guard_enable_fuse) next_guard_st = rwp_pkg::RWP_ST_FIRE;
         end
         rwp_pkg::RWP_ST_FIRE: next_guard_st = rwp_pkg::RWP_ST_HOLD;
         rwp_pkg::RWP_ST_HOLD: begin
            if (guard_clear_instr) next_guard_st = rwp_pkg::RWP_ST_RUN;
         end
         default: next_guard_st = rwp_pkg::RWP_ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         guard_st <= rwp_pkg::RWP_ST_RUN;
      end else begin
         guard_st <= next_guard_st;
      end
   end

   assign guard_reset = guard_st == rwp_pkg::RWP_ST_FIRE;

   // checks on the counter path
   wrap_sets_a: assert property (@(posedge clk) disable iff (!rst_b)
      cnt_wrap |=> rollover_pending && realtime_counter == 8'h00)
      else $error("wrap lost");

   pend_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
      rollover_pending && !pending_clear |=> rollover_pending)
      else $error("pending dropped");

   test_blocks_a: assert property (@(posedge clk) disable iff (!rst_b)
      counter_test && !counter_write |=> $stable(realtime_counter))
      else $error("test stepped");

   write_loads_a: assert property (@(posedge clk) disable iff (!rst_b)
      counter_write |=> realtime_counter == $past(counter_wdata))
      else $error("write lost");

   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      cnt_wrap && rollover_int_enable |=> rollover_irq || !rollover_int_enable)
      else $error("irq not raised");

   direct_step_a: assert property (@(posedge clk) disable iff (!rst_b)
      prescaler_assign && instr_cycle && !ext_source && !counter_test && !counter_write
      |=> realtime_counter == $past(realtime_counter) + 8'h01)
      else $error("no step");

   // a pin level seen between osc rises must not count
   osc_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      ext_source && prescaler_assign && !osc_rise && !counter_write
      |=> $stable(realtime_counter))
      else $error("pin counted off osc edge");

   // checks on the guard path
   guard_fires_a: assert property (@(posedge clk) disable iff (!rst_b)
      guard_expire && guard_enable_fuse && guard_st == rwp_pkg::RWP_ST_RUN |=> guard_reset)
      else $error("guard missed");

   no_fuse_a: assert property (@(posedge clk) disable iff (!rst_b)
      !guard_enable_fuse && guard_st == rwp_pkg::RWP_ST_RUN |=> !guard_reset)
      else $error("guard without fuse");

   fire_once_a: assert property (@(posedge clk) disable iff (!rst_b)
      guard_reset |=> !guard_reset)
      else $error("guard reset too long");

   guard_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      guard_st == rwp_pkg::RWP_ST_HOLD && !guard_clear_instr |=> !guard_reset)
      else $error("guard fired while held");

   guard_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      guard_clear_instr |=> guard_count == 8'h00)
      else $error("guard clear lost");

   one_user_a: assert property (@(posedge clk) disable iff (!rst_b)
      !prescaler_assign && !guard_osc_tick && !guard_clear_instr |=> $stable(guard_count))
      else $error("shared scaler");
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst_b = 0, instr_cycle = 0, counter_write = 0, counter_test = 0;
   logic guard_clear_instr = 0, pending_clear = 0, rollover_int_enable = 0;
   logic guard_enable_fuse = 0, run = 0, chk = 0;
   logic [7:0] option_bits = 8'h08, counter_wdata = 8'h00;
   logic osc_in_pin, counter_pin, rollover_pending, rollover_irq, guard_reset;
   rwp_pkg::rwp_byte_t realtime_counter;
   int n_rise, n_fall, n_mismatch = 0, samples_checked = 0, seed = 32'h3cb4, k, r0, f0;
   logic [9:0] q[$];
   always #2.5 clk = ~clk;
   rwp_timer #(.GUARD_DIV(4)) rwp_timer_i (.clk(clk), .rst_b(rst_b), .instr_cycle(instr_cycle),
      .osc_in_pin(osc_in_pin), .counter_pin(counter_pin), .option_bits(option_bits),
      .rollover_int_enable(rollover_int_enable), .guard_enable_fuse(guard_enable_fuse),
      .counter_write(counter_write), .counter_wdata(counter_wdata),
      .counter_test(counter_test), .guard_clear_instr(guard_clear_instr),
      .pending_clear(pending_clear), .realtime_counter(realtime_counter),
      .rollover_pending(rollover_pending), .rollover_irq(rollover_irq),
      .guard_reset(guard_reset));
   rwp_event_src rwp_event_src_i (.clk(clk), .run(run), .osc_in_pin(osc_in_pin),
      .counter_pin(counter_pin), .n_rise(n_rise), .n_fall(n_fall));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // {pending, irq, counter} is noted, the watcher compares the pre-edge values at the next clk rise
   task automatic note(input logic [9:0] exp);
      q.push_back(exp);
      chk = 1;
      tick(1);
      chk = 0;
   endtask
   always @(posedge clk) begin
      if (chk) begin
         check({rollover_pending, rollover_irq, realtime_counter}, q.pop_front());
      end
   end
   task automatic wr(input logic [7:0] v);
      counter_write = 1;
      counter_wdata = v;
      tick(1);
      counter_write = 0;
   endtask
   task automatic steps(input int n, input logic tst);
      repeat (n) begin
         instr_cycle = 1;
         counter_test = tst;
         tick(1);
      end
      instr_cycle = 0;
      counter_test = 0;
      tick(4);
   endtask
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      tick(2);
      rst_b = 1;
      note(10'h000);
      $display("test reset done");
      for (k = 0; k < 2; k++) begin
         rollover_int_enable = k[0];
         wr(8'hFD);
         steps(2, 0);
         steps(1, 1);
         steps(2, 0);
         note({1'b1, k[0], 8'h01});
         pending_clear = 1;
         tick(1);
         pending_clear = 0;
         note(10'h001);
      end
      r0 = $random(seed);
      f0 = ($random(seed) & 7) + 1;
      wr({1'b0, r0[6:0]});
      steps(f0, 0);
      note({2'b00, {1'b0, r0[6:0]} + f0[7:0]});
      $display("test instruction stepping done");
      for (k = 0; k < 8; k++) begin
         option_bits = {5'h00, k[2:0]};
         steps((2 << k) - 1, 0);
         wr(8'h00);
         steps(3 * (2 << k) - 1, 0);
         note(10'h002);
      end
      $display("test prescaler ratios done");
      for (k = 0; k < 2; k++) begin
         option_bits = {2'b00, 1'b1, k[0], 4'h8};
         tick(20);
         wr(8'h00);
         r0 = n_rise;
         f0 = n_fall;
         run = 1;
         tick(150);
         run = 0;
         tick(20);
         note({2'b00, 8'(k[0] ? n_fall - f0 : n_rise - r0)});
      end
      $display("test pin edges done");
      // guard ratio 1 halves the step rate; a stale prescaler count would fire early
      option_bits = 8'h09;
      guard_enable_fuse = 1;
      guard_clear_instr = 1;
      tick(1);
      guard_clear_instr = 0;
      r0 = 0;
      while (guard_reset !== 1'b1 && r0 < 3000) begin
         tick(1);
         r0++;
      end
      check((r0 >= 2045 && r0 <= 2048) ? 10'h001 : 10'h000, 10'h001);
      r0 = 0;
      repeat (1100) begin
         tick(1);
         r0 += int'(guard_reset);
      end
      check(10'(r0), 10'h000);
      $display("test guard timer done");
      print_verdict();
   end
endmodule
